// File: src/can_failsafe.sv
`timescale 1ns/10ps
`default_nettype none
// Contract
// RULE1: start dominant timer on txd falling
// RULE2: txd low too long disables transmitter
// RULE3: txd high clears the dominant timer
// RULE4: after time-out, txd high over 4us
// RULE5: floating txd and standby read high
// RULE6: controller keeps inputs high in standby
// RULE7: undervoltage switches transceiver off until recovery
// RULE8: standby input ignored during undervoltage
// RULE9: wake detector runs except in undervoltage; code runs it only in standby
// RULE10: long dominant phase never wakes
// RULE11: wake is dominant, recessive, dominant phases
// RULE12: phases shorter than filter time ignored
// RULE13: pattern must finish within wake time-out
// RULE14: overtemperature disables bus drivers
// RULE15: re-enable after cool and txd high
// RULE16: normal mode compares comparator with rxd
// RULE17: unfollowed dominant too long forces silent
// RULE18: silent ends on standby, unpowered, rxd low
// RULE19: standby input high selects standby
// RULE20: no normal mode while txd low
// RULE21: standby wake drives rxd low
// RULE22: durations are cycle-count parameters
// RULE23: silent holds driver recessive, rxd follows
module can_failsafe #(
    // durations in clock cycles
    parameter int unsigned DOM_TIMEOUT_CYCLES = failsafe_pkg::DOM_TIMEOUT_CYCLES_DEF, // RULE22
    parameter int unsigned FILTER_CYCLES = failsafe_pkg::FILTER_CYCLES_DEF,
    parameter int unsigned WAKE_TIMEOUT_CYCLES = failsafe_pkg::WAKE_TIMEOUT_CYCLES_DEF,
    parameter int unsigned CLAMP_DETECT_CYCLES = failsafe_pkg::CLAMP_DETECT_CYCLES_DEF
) (
    // clock, reset, enable
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic clk_en,
    // controller pins
    input wire logic txd_pin,
    input wire logic txd_pin_driven,
    input wire logic standby_select,
    input wire logic standby_select_driven,
    input wire logic rxd_pin_level,
    output logic rxd_out,
    // bus side
    input wire logic bus_level_comparator,
    input wire logic wake_comparator,
    output logic bus_drive_dominant,
    output logic bus_driver_enable,
    output logic bus_bias_enable,
    // supervision inputs
    input wire logic vcc_undervoltage,
    input wire logic io_supply_undervoltage,
    input wire logic overtemp,
    // status
    output failsafe_pkg::mode_t mode,
    output logic silent,
    output logic dom_timeout_active,
    output logic thermal_shutdown
);
    import failsafe_pkg::*;

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    logic [SYNC_WIDTH-1:0] raw_in;
    logic [SYNC_WIDTH-1:0] meta_reg;
    logic [SYNC_WIDTH-1:0] sync_reg;
    logic ot_meta_reg;
    logic ot_sync_reg;

    // an undriven pin is pulled up, so it reads high
    assign raw_in[SYNC_TXD] = txd_pin_driven ? txd_pin : 1'b1; // RULE5
    assign raw_in[SYNC_STANDBY_SELECT] = standby_select_driven ? standby_select : 1'b1; // RULE5
    assign raw_in[SYNC_RXD] = rxd_pin_level;
    assign raw_in[SYNC_CMP] = bus_level_comparator;
    assign raw_in[SYNC_WAKE] = wake_comparator;
    assign raw_in[SYNC_VCC_UV] = vcc_undervoltage;
    assign raw_in[SYNC_IO_UV] = io_supply_undervoltage;

    // two stages per pin; only the second stage is read
    genvar gi;
    generate
        for (gi = 0; gi < SYNC_WIDTH; gi = gi + 1) begin : g_sync
            always_ff @(posedge sys_clk or posedge reset) begin
                if (reset) begin
                    meta_reg[gi] <= SYNC_RESET[gi];
                    sync_reg[gi] <= SYNC_RESET[gi];
                end else if (clk_en) begin
                    meta_reg[gi] <= raw_in[gi];
                    sync_reg[gi] <= meta_reg[gi];
                end
            end
        end
    endgenerate

    // overtemperature flag has its own pair
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            ot_meta_reg <= 1'b0;
            ot_sync_reg <= 1'b0;
        end else if (clk_en) begin
            ot_meta_reg <= overtemp;
            ot_sync_reg <= ot_meta_reg;
        end
    end

    // ------------------------------------------------------------
    // decoded levels
    // ------------------------------------------------------------
    logic txd_high;
    logic standby_select_high;
    logic rxd_high;
    logic cmp_dom;
    logic uv_any;

    assign txd_high = sync_reg[SYNC_TXD];
    assign standby_select_high = sync_reg[SYNC_STANDBY_SELECT];
    assign rxd_high = sync_reg[SYNC_RXD];
    assign cmp_dom = sync_reg[SYNC_CMP];
    // either supply low is enough to drop off the bus
    assign uv_any = sync_reg[SYNC_VCC_UV] | sync_reg[SYNC_IO_UV];

    // ------------------------------------------------------------
    // timing units
    // ------------------------------------------------------------
    failsafe_link_if lnk ();
    mode_t mode_reg;
    logic dom_timeout_w;
    logic wake_hit_w;

    assign lnk.txd_high = txd_high;
    // wake comparator runs only in standby and only while both supplies are good
    assign lnk.wake_enable = !uv_any && (mode_reg == MODE_STANDBY); // RULE9
    assign lnk.bus_dom = sync_reg[SYNC_WAKE];
    assign dom_timeout_w = lnk.dom_timeout;
    assign wake_hit_w = lnk.wake_hit;

    dom_timeout #(
        .DOM_CYCLES(DOM_TIMEOUT_CYCLES)
    ) u_dom_timeout (
        .sys_clk(sys_clk),
        .reset(reset),
        .clk_en(clk_en),
        .lnk(lnk.timeout_unit)
    );

    wake_filter #(
        .FILTER_CYCLES(FILTER_CYCLES),
        .WAKE_CYCLES(WAKE_TIMEOUT_CYCLES)
    ) u_wake_filter (
        .sys_clk(sys_clk),
        .reset(reset),
        .clk_en(clk_en),
        .lnk(lnk.wake_unit)
    );

    // ------------------------------------------------------------
    // operating mode
    // ------------------------------------------------------------
    // standby input only matters once supplies are back
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            mode_reg <= MODE_UNPOWERED;
        end else if (clk_en) begin
            case (mode_reg)
                MODE_UNPOWERED: begin
                    if (!uv_any) begin
                        mode_reg <= MODE_STANDBY; // RULE7
                    end
                end
                MODE_STANDBY: begin
                    if (uv_any) begin
                        mode_reg <= MODE_UNPOWERED; // RULE8
                    end else if (!standby_select_high && txd_high) begin
                        mode_reg <= MODE_NORMAL; // RULE20
                    end
                end
                MODE_NORMAL: begin
                    if (uv_any) begin
                        mode_reg <= MODE_UNPOWERED; // RULE7
                    end else if (standby_select_high) begin
                        mode_reg <= MODE_STANDBY; // RULE19
                    end
                end
                default: begin
                    mode_reg <= MODE_UNPOWERED;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // overtemperature latch
    // ------------------------------------------------------------
    logic ot_latch_reg;

    // waiting for txd high stops the driver toggling on thermal drift
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            ot_latch_reg <= 1'b0;
        end else if (clk_en) begin
            if (ot_sync_reg) begin
                ot_latch_reg <= 1'b1; // RULE14
            end else if (txd_high) begin
                ot_latch_reg <= 1'b0; // RULE15
            end
        end
    end

    // ------------------------------------------------------------
    // rxd recessive clamp detection
    // ------------------------------------------------------------
    logic [31:0] clamp_cnt_reg;
    logic silent_reg;
    logic clamp_seen;

    // bus dominant while the rxd pin still reads high
    assign clamp_seen = (mode_reg == MODE_NORMAL) && cmp_dom && rxd_high; // RULE16

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            clamp_cnt_reg <= 32'h00000000;
        end else if (clk_en) begin
            if (!clamp_seen) begin
                clamp_cnt_reg <= 32'h00000000;
            end else if (clamp_cnt_reg <= CLAMP_DETECT_CYCLES) begin
                clamp_cnt_reg <= clamp_cnt_reg + 32'h00000001;
            end
        end
    end

    // release wins only through mode change or rxd low
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            silent_reg <= 1'b0;
        end else if (clk_en) begin
            if (mode_reg != MODE_NORMAL || !rxd_high) begin
                silent_reg <= 1'b0; // RULE18
            end else if (clamp_cnt_reg >= CLAMP_DETECT_CYCLES) begin
                silent_reg <= 1'b1; // RULE17
            end
        end
    end

    // ------------------------------------------------------------
    // wake request latch
    // ------------------------------------------------------------
    logic wake_req_reg;

    // held until the controller leaves standby
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            wake_req_reg <= 1'b0;
        end else if (clk_en) begin
            if (mode_reg != MODE_STANDBY) begin
                wake_req_reg <= 1'b0;
            end else if (wake_hit_w) begin
                wake_req_reg <= 1'b1; // RULE21
            end
        end
    end

    // ------------------------------------------------------------
    // registered outputs
    // ------------------------------------------------------------
    logic drv_ok;

    // any fail-safe condition keeps the bus recessive
    assign drv_ok = (mode_reg == MODE_NORMAL) && !silent_reg && !dom_timeout_w
                    && !ot_latch_reg;

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            bus_drive_dominant <= 1'b0;
            bus_driver_enable <= 1'b0;
            bus_bias_enable <= 1'b0;
        end else if (clk_en) begin
            bus_drive_dominant <= drv_ok && !txd_high; // RULE2
            bus_driver_enable <= drv_ok; // RULE23
            bus_bias_enable <= (mode_reg == MODE_NORMAL); // RULE7
        end
    end

    // rxd: comparator in normal (also when silent), wake flag in standby
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            rxd_out <= 1'b1;
        end else if (clk_en) begin
            case (mode_reg)
                MODE_NORMAL: rxd_out <= !cmp_dom; // RULE23
                MODE_STANDBY: rxd_out <= !wake_req_reg; // RULE21
                default: rxd_out <= 1'b1;
            endcase
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            mode <= MODE_UNPOWERED;
            silent <= 1'b0;
            dom_timeout_active <= 1'b0;
            thermal_shutdown <= 1'b0;
        end else if (clk_en) begin
            mode <= mode_reg;
            silent <= silent_reg;
            dom_timeout_active <= dom_timeout_w;
            thermal_shutdown <= ot_latch_reg;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    a_uv_off_bus: assert property (clk_en && uv_any ##1 clk_en |=> !bus_driver_enable) // RULE7
        else $error("driver enabled during undervoltage");
    a_uv_no_normal: assert property (clk_en && uv_any |=> mode_reg != MODE_NORMAL) // RULE8
        else $error("normal mode entered during undervoltage");
    a_txd_low_entry: assert property (clk_en && mode_reg == MODE_STANDBY && !txd_high
                                      |=> mode_reg != MODE_NORMAL) // RULE20
        else $error("normal mode entered with txd low");
    a_standby_select_enter: assert property (clk_en && mode_reg == MODE_NORMAL && standby_select_high && !uv_any
                                   |=> mode_reg == MODE_STANDBY) // RULE19
        else $error("standby not entered");
    a_timeout_quiet: assert property (clk_en && dom_timeout_w |=> !bus_drive_dominant) // RULE2
        else $error("bus driven after dominant time-out");
    a_ot_off: assert property (clk_en && ot_latch_reg |=> !bus_driver_enable) // RULE14
        else $error("driver enabled while hot");
    a_ot_hold: assert property (clk_en && ot_latch_reg && !txd_high
                                |=> ot_latch_reg) // RULE15
        else $error("thermal latch released with txd low");
    a_silent_release: assert property (clk_en && silent_reg && !rxd_high
                                       |=> !silent_reg) // RULE18
        else $error("silent held with rxd low");
    a_silent_follow: assert property (clk_en && silent_reg && mode_reg == MODE_NORMAL
                                      |=> rxd_out == !$past(cmp_dom)) // RULE23
        else $error("rxd does not follow comparator in silent");
    a_wake_rxd: assert property (clk_en && wake_req_reg && mode_reg == MODE_STANDBY
                                 |=> !rxd_out) // RULE21
        else $error("wake request not shown on rxd");

    c_wake: cover property (wake_req_reg && !rxd_out);
    c_silent: cover property (silent_reg);
    c_timeout: cover property (dom_timeout_w ##[1:1000] !dom_timeout_w);
    c_thermal: cover property (ot_latch_reg ##1 !ot_latch_reg);
endmodule
`default_nettype wire

// File: src/failsafe_pkg.sv
package failsafe_pkg;
    // ------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 10;
    // a dominant time-out needs txd high for more than this time
    localparam int unsigned RELEASE_HIGH_TIME_NS = 4000;
    // least time: round up to whole cycles
    localparam int unsigned RELEASE_HIGH_CYCLES =
        (RELEASE_HIGH_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // default durations in cycles, each a top-level parameter
    localparam int unsigned DOM_TIMEOUT_CYCLES_DEF = 100000;
    localparam int unsigned FILTER_CYCLES_DEF = 100;
    localparam int unsigned WAKE_TIMEOUT_CYCLES_DEF = 100000;
    localparam int unsigned CLAMP_DETECT_CYCLES_DEF = 100;
    // ------------------------------------------------------------
    // input synchroniser layout
    // ------------------------------------------------------------
    localparam int unsigned SYNC_WIDTH = 7;
    localparam int unsigned SYNC_TXD = 0;
    localparam int unsigned SYNC_STANDBY_SELECT = 1;
    localparam int unsigned SYNC_RXD = 2;
    localparam int unsigned SYNC_CMP = 3;
    localparam int unsigned SYNC_WAKE = 4;
    localparam int unsigned SYNC_VCC_UV = 5;
    localparam int unsigned SYNC_IO_UV = 6;
    // reset value of every synchroniser stage: pins idle high or inactive
    localparam logic [6:0] SYNC_RESET = 7'h07;
    typedef enum logic [1:0] {MODE_UNPOWERED, MODE_STANDBY, MODE_NORMAL} mode_t;
endpackage

// File: src/failsafe_link_if.sv
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------------------------
// link between the core and its two timing units
// ------------------------------------------------------------
interface failsafe_link_if;
    logic txd_high;
    logic dom_timeout;
    logic wake_enable;
    logic bus_dom;
    logic wake_hit;
    modport core (output txd_high, output wake_enable, output bus_dom,
                  input dom_timeout, input wake_hit);
    modport timeout_unit (input txd_high, output dom_timeout);
    modport wake_unit (input wake_enable, input bus_dom, output wake_hit);
endinterface
`default_nettype wire

// File: src/dom_timeout.sv
`timescale 1ns/10ps
`default_nettype none
module dom_timeout #(
    parameter int unsigned DOM_CYCLES = failsafe_pkg::DOM_TIMEOUT_CYCLES_DEF
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic clk_en,
    failsafe_link_if.timeout_unit lnk
);
    import failsafe_pkg::*;
    logic [31:0] low_cnt_reg;
    logic [31:0] high_cnt_reg;
    logic tripped_reg;
    // timer runs from the falling edge of txd, cleared when high
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            low_cnt_reg <= 32'h00000000;
        end else if (clk_en) begin
            if (lnk.txd_high) begin
                low_cnt_reg <= 32'h00000000; // RULE3
            end else if (low_cnt_reg <= DOM_CYCLES) begin
                low_cnt_reg <= low_cnt_reg + 32'h00000001; // RULE1
            end
        end
    end
    // high time after a trip; saturates to avoid wrap
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            high_cnt_reg <= 32'h00000000;
        end else if (clk_en) begin
            if (!lnk.txd_high || !tripped_reg) begin
                high_cnt_reg <= 32'h00000000;
            end else if (high_cnt_reg <= RELEASE_HIGH_CYCLES) begin
                high_cnt_reg <= high_cnt_reg + 32'h00000001;
            end
        end
    end
    // trip latch; a short high pulse must not re-arm the driver
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            tripped_reg <= 1'b0;
        end else if (clk_en) begin
            if (!lnk.txd_high && low_cnt_reg >= DOM_CYCLES) begin
                tripped_reg <= 1'b1; // RULE2
            end else if (high_cnt_reg >= RELEASE_HIGH_CYCLES) begin
                tripped_reg <= 1'b0; // RULE4
            end
        end
    end
    assign lnk.dom_timeout = tripped_reg;
endmodule
`default_nettype wire

// File: src/wake_filter.sv
`timescale 1ns/10ps
`default_nettype none
module wake_filter #(
    parameter int unsigned FILTER_CYCLES = failsafe_pkg::FILTER_CYCLES_DEF,
    parameter int unsigned WAKE_CYCLES = failsafe_pkg::WAKE_TIMEOUT_CYCLES_DEF
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic clk_en,
    failsafe_link_if.wake_unit lnk
);
    import failsafe_pkg::*;
    typedef enum logic [1:0] {W_IDLE, W_DOM1, W_REC, W_DONE} wstate_t;
    wstate_t state_reg;
    logic [31:0] stable_cnt_reg;
    logic [31:0] window_reg;
    logic raw_last_reg;
    logic filt_dom_reg;
    // level filter: phases shorter than the filter time never reach filt_dom
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            raw_last_reg <= 1'b0;
            stable_cnt_reg <= 32'h00000000;
            filt_dom_reg <= 1'b0;
        end else if (clk_en) begin
            raw_last_reg <= lnk.bus_dom;
            if (!lnk.wake_enable || lnk.bus_dom != raw_last_reg) begin
                stable_cnt_reg <= 32'h00000000;
            end else if (stable_cnt_reg < FILTER_CYCLES) begin
                stable_cnt_reg <= stable_cnt_reg + 32'h00000001;
            end
            if (!lnk.wake_enable) begin
                filt_dom_reg <= 1'b0;
            end else if (stable_cnt_reg + 32'h00000001 >= FILTER_CYCLES) begin
                filt_dom_reg <= raw_last_reg; // RULE12
            end
        end
    end
    // dominant-recessive-dominant sequencer with a time window
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            state_reg <= W_IDLE;
            window_reg <= 32'h00000000;
        end else if (clk_en) begin
            window_reg <= (state_reg == W_IDLE) ? 32'h00000000
                                                : window_reg + 32'h00000001;
            case (state_reg)
                W_IDLE: begin
                    if (lnk.wake_enable && filt_dom_reg) begin
                        state_reg <= W_DOM1; // RULE11
                    end
                end
                W_DOM1: begin
                    // a long dominant stays here and never wakes
                    if (!filt_dom_reg) begin
                        state_reg <= W_REC; // RULE10
                    end
                end
                W_REC: begin
                    if (filt_dom_reg) begin
                        state_reg <= W_DONE; // RULE11
                    end
                end
                default: begin
                    state_reg <= W_IDLE;
                end
            endcase
            if (!lnk.wake_enable) begin
                state_reg <= W_IDLE; // RULE9
            end else if (state_reg != W_IDLE && state_reg != W_DONE
                         && window_reg >= WAKE_CYCLES) begin
                state_reg <= W_IDLE; // RULE13
            end
        end
    end
    assign lnk.wake_hit = (state_reg == W_DONE);
endmodule
`default_nettype wire

// File: verif/ctrl_model.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// controller side of the transceiver pins
// ----------------------------------------
module ctrl_model (
    // intents from the bench
    input wire logic want_txd,
    input wire logic want_standby_select,
    input wire logic float_pins,
    // pins toward the device
    output logic txd_pin,
    output logic txd_pin_driven,
    output logic standby_select,
    output logic standby_select_driven
);
    // txd parked high in standby to save pull-up current; floating shows low
    assign txd_pin = float_pins ? 1'b0 : (want_txd | want_standby_select);
    assign standby_select = float_pins ? 1'b0 : want_standby_select;
    // released pins: only the device's pull-up can make them high
    assign txd_pin_driven = ~float_pins;
    assign standby_select_driven = ~float_pins;
endmodule
`default_nettype wire

// File: verif/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import failsafe_pkg::*;
    logic sys_clk = 0, reset = 1, want_txd = 1, want_standby_select = 1, float_pins = 0, clk_en = 1;
    logic rxd_pin_level = 1, bus_level_comparator = 0, wake_comparator = 0;
    logic vcc_uv = 0, io_uv = 0, overtemp = 0;
    logic txd_pin, txd_pin_driven, standby_select, standby_select_driven;
    logic rxd_out, drv_dom, drv_en, silent, dom_to, tsd, bias;
    mode_t mode;
    int failures = 0, comparisons = 0;
    always #5 sys_clk = ~sys_clk;
    ctrl_model ctrl (.want_txd(want_txd), .want_standby_select(want_standby_select), .float_pins(float_pins),
        .txd_pin(txd_pin), .txd_pin_driven(txd_pin_driven), .standby_select(standby_select),
        .standby_select_driven(standby_select_driven));
    // short counts keep the run brief
    can_failsafe #(.DOM_TIMEOUT_CYCLES(50), .FILTER_CYCLES(4), .WAKE_TIMEOUT_CYCLES(100),
        .CLAMP_DETECT_CYCLES(8)) dut (.sys_clk(sys_clk), .reset(reset), .clk_en(clk_en),
        .txd_pin(txd_pin), .txd_pin_driven(txd_pin_driven), .standby_select(standby_select),
        .standby_select_driven(standby_select_driven), .rxd_pin_level(rxd_pin_level),
        .rxd_out(rxd_out), .bus_level_comparator(bus_level_comparator),
        .wake_comparator(wake_comparator), .bus_drive_dominant(drv_dom),
        .bus_driver_enable(drv_en), .bus_bias_enable(bias), .vcc_undervoltage(vcc_uv),
        .io_supply_undervoltage(io_uv), .overtemp(overtemp), .mode(mode), .silent(silent),
        .dom_timeout_active(dom_to), .thermal_shutdown(tsd));
    // inputs always move 1 ns after the edge
    task automatic step(int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic chk(string name, logic [1:0] exp, logic [1:0] got);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("BAD %s expected %0h seen %0h", name, exp, got);
        end
    endtask
    task automatic go_normal();
        want_standby_select = 0;
        want_txd = 1;
        step(10);
    endtask
    task automatic t_mode();
        want_standby_select = 0;
        want_txd = 0;
        step(10);
        chk("mode txd low", MODE_STANDBY, mode);
        go_normal();
        chk("mode normal", MODE_NORMAL, mode);
        chk("drv_en normal", 1, drv_en);
        chk("bias normal", 1, bias);
        // enable low: a standby request must not be taken
        clk_en = 0;
        want_standby_select = 1;
        step(10);
        chk("frozen mode", MODE_NORMAL, mode);
        clk_en = 1;
        want_standby_select = 0;
        step(2);
    endtask
    task automatic t_dom();
        want_txd = 0;
        step(30);
        chk("dominant", 1, drv_dom);
        want_txd = 1;
        step(4);
        want_txd = 0;
        step(40);
        chk("timer cleared", 0, dom_to);
        step(30);
        chk("timeout", 1, dom_to);
        chk("drv off", 0, drv_en);
        want_txd = 1;
        step(200);
        chk("still tripped", 1, dom_to);
        step(250);
        chk("released", 0, dom_to);
    endtask
    task automatic t_ot();
        overtemp = 1;
        step(8);
        chk("ot latch", 1, tsd);
        chk("ot drv", 0, drv_en);
        want_txd = 0;
        overtemp = 0;
        step(8);
        chk("ot txd low", 0, drv_en);
        want_txd = 1;
        step(8);
        chk("ot cleared", 0, tsd);
    endtask
    task automatic t_clamp();
        bus_level_comparator = 1;
        step(4);
        bus_level_comparator = 0;
        step(8);
        chk("short dom", 0, silent);
        bus_level_comparator = 1;
        step(20);
        chk("silent", 1, silent);
        chk("silent drv", 0, drv_en);
        chk("silent rxd", 0, rxd_out);
        rxd_pin_level = 0;
        step(8);
        chk("silent off", 0, silent);
        bus_level_comparator = 0;
        rxd_pin_level = 1;
        step(8);
    endtask
    task automatic t_supply();
        float_pins = 1;
        step(10);
        chk("floating", MODE_STANDBY, mode);
        float_pins = 0;
        step(10);
        vcc_uv = 1;
        step(8);
        chk("uv mode", MODE_UNPOWERED, mode);
        chk("uv drv", 0, drv_en);
        chk("uv bias", 0, bias);
        vcc_uv = 0;
        io_uv = 1;
        step(10);
        chk("standby_select ignored", MODE_UNPOWERED, mode);
        io_uv = 0;
        step(20);
        chk("recovered", MODE_NORMAL, mode);
    endtask
    task automatic wake(logic lvl, int n);
        wake_comparator = lvl;
        step(n);
    endtask
    task automatic t_wake();
        want_standby_select = 1;
        step(10);
        wake(1, 200);
        wake(0, 120);
        chk("long dom", 1, rxd_out);
        wake(1, 10);
        wake(0, 150);
        wake(1, 10);
        wake(0, 120);
        chk("too slow", 1, rxd_out);
        for (int i = 0; i < 3; i++) begin
            wake(1, 2);
            wake(0, 2);
        end
        step(10);
        chk("glitches", 1, rxd_out);
        wake(0, 120);
        wake(1, 10);
        wake(0, 10);
        wake(1, 10);
        wake(0, 10);
        chk("wake", 0, rxd_out);
    endtask
    task automatic results();
        if (failures == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        step(10);
        reset = 0;
        step(10);
        t_mode();
        t_dom();
        t_ot();
        t_clamp();
        t_supply();
        t_wake();
        results();
    end
    // run needs about 1540 cycles
    initial begin
        #200000;
        failures++;
        results();
    end
endmodule
`default_nettype wire
